// [rtl/ioc_buf2.sv]
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes one clock; the head word is always held in a register.
 */
module ioc_buf2 #(
    parameter int WIDTH = 32
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rstn_in,
    input  wire logic             flush_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic      [WIDTH-1:0] out_data_out,
    input  wire logic             out_ready_in
);

    typedef struct packed {
        logic [WIDTH-1:0] head;
        logic [WIDTH-1:0] tail;
        logic [1:0]       cnt;
    } ioc_buf_t;

    ioc_buf_t q;
    ioc_buf_t d;
    logic     push;
    logic     pop;
    logic [1:0] left;

    assign in_ready_out  = (q.cnt != 2'h2);
    assign out_valid_out = (q.cnt != 2'h0);
    assign out_data_out  = q.head;
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_comb begin
        d    = q;
        left = q.cnt - {1'b0, pop};
        if (pop) begin
            d.head = q.tail;
        end
        if (push) begin
            if (left == 2'h0) begin
                d.head = in_data_in;
            end else begin
                d.tail = in_data_in;
            end
        end
        d.cnt = left + {1'b0, push};
        if (flush_in) begin
            d.cnt = 2'h0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

// [rtl/ioc_conn_fsm.sv]
/*
 * I/O connection state logic of the network adapter: connection states,
 * drive enable, hot start, cyclic period tick, one explicit message
 * channel each way, status attribute and indicators.
 * Assumes all inputs are synchronous one-cycle events or levels from the
 * protocol engine; a period outside 1 to 100 ms makes the setup fail.
 */
`include "ioc_regs.svh"

module ioc_conn_fsm #(
    parameter int WIDTH     = 32,
    parameter int MS_CYCLES = `IOC_MS_CYCLES
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rstn_in,
    input  wire logic             open_req_in,
    input  wire logic             open_large_req_in,
    input  wire logic [6:0]       period_ms_in,
    input  wire logic             setup_ok_in,
    input  wire logic             setup_fail_in,
    input  wire logic             run_notify_in,
    input  wire logic             idle_notify_in,
    input  wire logic             close_req_in,
    input  wire logic             close_ok_in,
    input  wire logic             close_fail_in,
    input  wire logic             conn_timeout_in,
    input  wire logic             cmd_valid_in,
    input  wire logic [WIDTH-1:0] cmd_data_in,
    output logic                  cmd_ready_out,
    output logic                  drv_cmd_valid_out,
    output logic      [WIDTH-1:0] drv_cmd_data_out,
    input  wire logic             drv_cmd_ready_in,
    output logic      [2:0]       conn_state_out,
    output logic                  drive_enable_out,
    output logic                  hot_start_out,
    output logic                  io_cycle_out,
    input  wire logic             msg_tx_req_in,
    input  wire logic             msg_tx_done_in,
    output logic                  msg_tx_busy_out,
    input  wire logic             msg_rx_req_in,
    input  wire logic             msg_rx_done_in,
    output logic                  msg_rx_busy_out,
    output logic                  msg_refused_out,
    input  wire logic [1:0]       port_link_in,
    input  wire logic [1:0]       port_speed100_in,
    input  wire logic [1:0]       port_full_duplex_in,
    input  wire logic [1:0]       port_activity_in,
    output logic      [3:0]       port_mode_out,
    input  wire logic             attr_rd_in,
    input  wire logic [7:0]       attr_class_in,
    input  wire logic [7:0]       attr_inst_in,
    input  wire logic [7:0]       attr_id_in,
    output logic      [15:0]      attr_data_out,
    output logic                  attr_hit_out,
    output logic                  led_net_out,
    output logic                  led_mod_out,
    output logic      [1:0]       led_link_act_out
);

    localparam int MSW = $clog2(MS_CYCLES);

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        ioc_pkg::ioc_conn_t state;
        logic               from_run;
        logic               period_ok;
        logic [6:0]         period;
        logic [MSW-1:0]     ms_cnt;
        logic [6:0]         cyc_cnt;
        logic               io_cycle;
        logic               hot_start;
        logic               tx_busy;
        logic               rx_busy;
        logic               refused;
        logic [3:0]         port_mode;
        logic [15:0]        attr_data;
        logic               attr_hit;
        logic [9:0]         blink_cnt;
        logic               blink;
        logic [1:0][9:0]    act_cnt;
        logic [1:0]         led_link;
    } ioc_state_t;

    ioc_state_t q;
    ioc_state_t d;
    logic       ms_tick;
    logic       run;
    logic       buf_ready;
    logic       flush;

    // ------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------
    function automatic logic [15:0] status_word(input ioc_pkg::ioc_conn_t s);
        logic [15:0] w;
        logic [3:0]  ext;
        w   = 16'h0000;
        ext = `IOC_EXT_NONEXIST;
        case (s)
            ioc_pkg::ioc_config:   ext = `IOC_EXT_CONFIG;
            ioc_pkg::ioc_est_idle: ext = `IOC_EXT_IDLE;
            ioc_pkg::ioc_est_run:  ext = `IOC_EXT_RUN;
            ioc_pkg::ioc_closing:  ext = `IOC_EXT_CLOSING;
            default:               ext = `IOC_EXT_NONEXIST;
        endcase
        w[`IOC_STAT_OWNED]      = (s == ioc_pkg::ioc_est_idle) || (s == ioc_pkg::ioc_est_run)
                                  || (s == ioc_pkg::ioc_closing);
        w[`IOC_STAT_CONFIGURED] = (s != ioc_pkg::ioc_nonexist);
        w[`IOC_STAT_EXT_LSB +: 4] = ext;
        return w;
    endfunction

    assign ms_tick = (q.ms_cnt == MSW'(MS_CYCLES - 1));
    assign run     = (q.state == ioc_pkg::ioc_est_run);
    assign flush   = (d.state != ioc_pkg::ioc_est_run);
    assign cmd_ready_out = run ? buf_ready : 1'b1;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d           = q;
        d.hot_start = 1'b0;
        d.io_cycle  = 1'b0;
        d.refused   = 1'b0;
        d.attr_hit  = 1'b0;
        d.ms_cnt    = ms_tick ? '0 : q.ms_cnt + MSW'(1);

        if (conn_timeout_in && (q.state != ioc_pkg::ioc_nonexist)) begin
            d.state = ioc_pkg::ioc_nonexist;
            d.hot_start = run;
        end else begin
            case (q.state)
                ioc_pkg::ioc_nonexist: begin
                    if (open_req_in || open_large_req_in) begin
                        d.state     = ioc_pkg::ioc_config;
                        d.period    = period_ms_in;
                        d.period_ok = (period_ms_in >= `IOC_PERIOD_MIN_MS)
                                      && (period_ms_in <= `IOC_PERIOD_MAX_MS);
                    end
                end
                ioc_pkg::ioc_config: begin
                    if (setup_fail_in || (setup_ok_in && !q.period_ok)) begin
                        d.state = ioc_pkg::ioc_nonexist;
                    end else if (setup_ok_in) begin
                        d.state   = ioc_pkg::ioc_est_idle;
                        d.cyc_cnt = 7'h00;
                    end
                end
                ioc_pkg::ioc_est_idle: begin
                    if (close_req_in) begin
                        d.state    = ioc_pkg::ioc_closing;
                        d.from_run = 1'b0;
                    end else if (run_notify_in) begin
                        d.state = ioc_pkg::ioc_est_run;
                    end
                end
                ioc_pkg::ioc_est_run: begin
                    if (close_req_in) begin
                        d.state    = ioc_pkg::ioc_closing;
                        d.from_run = 1'b1;
                    end else if (idle_notify_in) begin
                        d.state     = ioc_pkg::ioc_est_idle;
                        d.hot_start = 1'b1;
                    end
                end
                ioc_pkg::ioc_closing: begin
                    if (close_ok_in) begin
                        d.state     = ioc_pkg::ioc_nonexist;
                        d.hot_start = q.from_run;
                    end else if (close_fail_in) begin
                        d.state = q.from_run ? ioc_pkg::ioc_est_run : ioc_pkg::ioc_est_idle;
                    end
                end
                default: begin
                    d.state = ioc_pkg::ioc_nonexist;
                end
            endcase
        end

        if ((q.state == ioc_pkg::ioc_est_idle) || (q.state == ioc_pkg::ioc_est_run)) begin
            if (ms_tick) begin
                if (q.cyc_cnt >= q.period - 7'h01) begin
                    d.cyc_cnt  = 7'h00;
                    d.io_cycle = 1'b1;
                end else begin
                    d.cyc_cnt = q.cyc_cnt + 7'h01;
                end
            end
        end else begin
            d.cyc_cnt = 7'h00;
        end

        if (msg_tx_req_in && q.tx_busy) begin
            d.refused = 1'b1;
        end else if (msg_tx_req_in) begin
            d.tx_busy = 1'b1;
        end else if (msg_tx_done_in) begin
            d.tx_busy = 1'b0;
        end
        if (msg_rx_req_in && q.rx_busy) begin
            d.refused = 1'b1;
        end else if (msg_rx_req_in) begin
            d.rx_busy = 1'b1;
        end else if (msg_rx_done_in) begin
            d.rx_busy = 1'b0;
        end

        if (attr_rd_in) begin
            d.attr_hit = (attr_class_in == `IOC_STAT_CLASS) && (attr_inst_in == `IOC_STAT_INST)
                         && (attr_id_in == `IOC_STAT_ATTR);
            d.attr_data = d.attr_hit ? status_word(q.state) : 16'h0000;
        end

        if (ms_tick) begin
            if (q.blink_cnt == `IOC_BLINK_MS - 10'h001) begin
                d.blink_cnt = 10'h000;
                d.blink     = !q.blink;
            end else begin
                d.blink_cnt = q.blink_cnt + 10'h001;
            end
        end
        for (int p = 0; p < 2; p++) begin
            if (port_link_in[p]) begin
                d.port_mode[2*p +: 2] = {port_full_duplex_in[p], port_speed100_in[p]};
            end
            if (port_activity_in[p]) begin
                d.act_cnt[p] = `IOC_ACT_MS;
            end else if (ms_tick && (q.act_cnt[p] != 10'h000)) begin
                d.act_cnt[p] = q.act_cnt[p] - 10'h001;
            end
            d.led_link[p] = port_link_in[p] && !((q.act_cnt[p] != 10'h000) && q.blink);
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Command buffer
    // ------------------------------------------------------------------
    ioc_buf2 #(
        .WIDTH (WIDTH)
    ) u_cmd_buf (
        .ref_clk_in    (ref_clk_in),
        .rstn_in       (rstn_in),
        .flush_in      (flush),
        .in_valid_in   (cmd_valid_in && run),
        .in_data_in    (cmd_data_in),
        .in_ready_out  (buf_ready),
        .out_valid_out (drv_cmd_valid_out),
        .out_data_out  (drv_cmd_data_out),
        .out_ready_in  (drv_cmd_ready_in && run)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign conn_state_out   = q.state;
    assign drive_enable_out = run;
    assign hot_start_out    = q.hot_start;
    assign io_cycle_out     = q.io_cycle;
    assign msg_tx_busy_out  = q.tx_busy;
    assign msg_rx_busy_out  = q.rx_busy;
    assign msg_refused_out  = q.refused;
    assign port_mode_out    = q.port_mode;
    assign attr_data_out    = q.attr_data;
    assign attr_hit_out     = q.attr_hit;
    assign led_net_out      = (q.state == ioc_pkg::ioc_est_idle)
                              || (q.state == ioc_pkg::ioc_est_run)
                              || (((q.state == ioc_pkg::ioc_config)
                                   || (q.state == ioc_pkg::ioc_closing)) && q.blink);
    assign led_mod_out      = 1'b1;
    assign led_link_act_out = q.led_link;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_in_run;
        conn_state_out == ioc_pkg::ioc_est_run;
    endsequence

    sequence s_idle_hot;
        (conn_state_out == ioc_pkg::ioc_est_idle) && hot_start_out;
    endsequence

    a_open_to_config: assert property (
        (q.state == ioc_pkg::ioc_nonexist) && open_large_req_in && !conn_timeout_in
        |=> conn_state_out == ioc_pkg::ioc_config)
        else $error("Open request did not reach Configuring.");

    a_setup_fail_back: assert property (
        (q.state == ioc_pkg::ioc_config) && setup_fail_in
        |=> conn_state_out == ioc_pkg::ioc_nonexist)
        else $error("Failed setup did not return to Non-Existent.");

    a_setup_ok_idle: assert property (
        (q.state == ioc_pkg::ioc_config) && setup_ok_in && q.period_ok && !setup_fail_in
        && !conn_timeout_in |=> (conn_state_out == ioc_pkg::ioc_est_idle) && !drive_enable_out)
        else $error("Successful setup did not enter idle.");

    a_drive_only_run: assert property (
        drv_cmd_valid_out && drv_cmd_ready_in |-> s_in_run ##0 drive_enable_out)
        else $error("Command reached the drive outside Run.");

    a_run_enable: assert property (
        (q.state == ioc_pkg::ioc_est_idle) && run_notify_in && !close_req_in && !conn_timeout_in
        |=> s_in_run ##0 drive_enable_out)
        else $error("Run notification did not enable driving.");

    a_idle_hot_start: assert property (
        s_in_run ##0 idle_notify_in && !close_req_in && !conn_timeout_in |=> s_idle_hot)
        else $error("Idle notification in Run lacked hot start.");

    a_close_closing: assert property (
        ((q.state == ioc_pkg::ioc_est_idle) || run) && close_req_in && !conn_timeout_in
        |=> conn_state_out == ioc_pkg::ioc_closing)
        else $error("Close request did not reach Closing.");

    a_close_run_hot: assert property (
        (q.state == ioc_pkg::ioc_closing) && close_ok_in && !conn_timeout_in
        |=> (conn_state_out == ioc_pkg::ioc_nonexist) && (hot_start_out == $past(q.from_run)))
        else $error("Completed close gave wrong state or hot start.");

    a_timeout_hot: assert property (
        s_in_run ##0 conn_timeout_in |=> (conn_state_out == ioc_pkg::ioc_nonexist) && hot_start_out)
        else $error("Timeout in Run lacked hot start.");

    a_hot_from_run: assert property (
        hot_start_out |-> $past(conn_state_out) == ioc_pkg::ioc_est_run
                          || $past(conn_state_out) == ioc_pkg::ioc_closing)
        else $error("Hot start without leaving Run.");

endmodule

// [rtl/ioc_pkg.sv]
/*
 * Types shared by the I/O connection state logic.
 * Assumes nothing beyond a SystemVerilog elaborator.
 */
package ioc_pkg;

    // ------------------------------------------------------------------
    // Connection states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ioc_nonexist,
        ioc_config,
        ioc_est_idle,
        ioc_est_run,
        ioc_closing
    } ioc_conn_t;

endpackage

// [rtl/ioc_regs.svh]
/*
 * Constants for the I/O connection state logic: timing counts, period
 * limits, status word fields and the identity of the status attribute.
 * Assumes a 100 MHz system clock.
 */
`ifndef IOC_REGS_SVH
`define IOC_REGS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define IOC_CLK_PERIOD_NS   10
`define IOC_TICK_NS         1000000
`define IOC_MS_CYCLES       (`IOC_TICK_NS / `IOC_CLK_PERIOD_NS)
`define IOC_PERIOD_MIN_MS   7'h01
`define IOC_PERIOD_MAX_MS   7'h64
`define IOC_BLINK_MS        10'h1F4
`define IOC_ACT_MS          10'h032

// ----------------------------------------------------------------------
// Status attribute location and layout
// ----------------------------------------------------------------------
`define IOC_STAT_CLASS      8'h01
`define IOC_STAT_INST       8'h01
`define IOC_STAT_ATTR       8'h05
`define IOC_STAT_OWNED      0
`define IOC_STAT_CONFIGURED 2
`define IOC_STAT_EXT_LSB    4
`define IOC_EXT_NONEXIST    4'h0
`define IOC_EXT_CONFIG      4'h1
`define IOC_EXT_CLOSING     4'h5
`define IOC_EXT_RUN         4'h6
`define IOC_EXT_IDLE        4'h7

`endif

// [testbench/ioc_conn_fsm_bench.sv]
/*
 * Self-checking bench of the connection state logic with a master model.
 * Assumes the design package and header are compiled first.
 */
module ioc_conn_fsm_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MSC = 10;
    logic        ref_clk_in, rstn_in, go, cmd_valid_in, drv_cmd_ready_in, attr_rd_in;
    logic        msg_tx_req_in, msg_tx_done_in, msg_rx_req_in, msg_rx_done_in;
    logic        cmd_ready_out, drv_cmd_valid_out, drive_enable_out, hot_start_out;
    logic        io_cycle_out, msg_tx_busy_out, msg_rx_busy_out, msg_refused_out;
    logic        attr_hit_out, led_net_out, led_mod_out;
    logic [3:0]  op, port_mode_out;
    logic [9:0]  ev;
    logic [6:0]  period;
    logic [2:0]  conn_state_out;
    logic [31:0] cmd_data_in, drv_cmd_data_out;
    logic [1:0]  port_link_in, port_speed100_in, port_full_duplex_in, port_activity_in;
    logic [1:0]  led_link_act_out;
    logic [7:0]  attr_class_in, attr_inst_in, attr_id_in;
    logic [15:0] attr_data_out;
    int          fails, checks;

    ioc_master_model i_master (.go_in(go), .op_in(op), .ev_out(ev), .period_ms_out(period));

    ioc_conn_fsm #(.WIDTH(32), .MS_CYCLES(MSC)) i_dut (
        .ref_clk_in, .rstn_in, .open_req_in(ev[0]), .open_large_req_in(ev[1]),
        .period_ms_in(period), .setup_ok_in(ev[2]), .setup_fail_in(ev[3]),
        .run_notify_in(ev[4]), .idle_notify_in(ev[5]), .close_req_in(ev[6]),
        .close_ok_in(ev[7]), .close_fail_in(ev[8]), .conn_timeout_in(ev[9]),
        .cmd_valid_in, .cmd_data_in, .cmd_ready_out, .drv_cmd_valid_out,
        .drv_cmd_data_out, .drv_cmd_ready_in, .conn_state_out, .drive_enable_out,
        .hot_start_out, .io_cycle_out, .msg_tx_req_in, .msg_tx_done_in, .msg_tx_busy_out,
        .msg_rx_req_in, .msg_rx_done_in, .msg_rx_busy_out, .msg_refused_out,
        .port_link_in, .port_speed100_in, .port_full_duplex_in, .port_activity_in,
        .port_mode_out, .attr_rd_in, .attr_class_in, .attr_inst_in, .attr_id_in,
        .attr_data_out, .attr_hit_out, .led_net_out, .led_mod_out, .led_link_act_out
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic step(input logic [3:0] k, input logic [2:0] s, input logic h);
        @(posedge ref_clk_in);
        op <= k;
        go <= 1'b1;
        @(posedge ref_clk_in);
        go <= 1'b0;
        #1;
        chk("state", {29'h0, s}, {29'h0, conn_state_out});
        chk("hot_start", {31'h0, h}, {31'h0, hot_start_out});
    endtask

    task automatic pulse(input logic [4:0] v);
        @(posedge ref_clk_in);
        {msg_tx_req_in, msg_tx_done_in, msg_rx_req_in, msg_rx_done_in, attr_rd_in} <= v;
        @(posedge ref_clk_in);
        {msg_tx_req_in, msg_tx_done_in, msg_rx_req_in, msg_rx_done_in, attr_rd_in} <= 5'h00;
        #1;
    endtask

    task automatic conclude;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_conn;
        step(4'h5, 3'h0, 1'b0);
        chk("drive_en", 32'h0, {31'h0, drive_enable_out});
        step(4'h0, 3'h1, 1'b0);
        step(4'h3, 3'h0, 1'b0);
        step(4'h1, 3'h1, 1'b0);
        step(4'h2, 3'h2, 1'b0);
        chk("drive_en", 32'h0, {31'h0, drive_enable_out});
        step(4'h4, 3'h3, 1'b0);
        chk("drive_en", 32'h1, {31'h0, drive_enable_out});
        step(4'h5, 3'h2, 1'b1);
        step(4'h4, 3'h3, 1'b0);
        step(4'h6, 3'h4, 1'b0);
        step(4'h8, 3'h3, 1'b0);
        step(4'h6, 3'h4, 1'b0);
        step(4'h7, 3'h0, 1'b1);
        step(4'h0, 3'h1, 1'b0);
        step(4'h2, 3'h2, 1'b0);
        step(4'h6, 3'h4, 1'b0);
        step(4'h7, 3'h0, 1'b0);
        step(4'h0, 3'h1, 1'b0);
        step(4'h9, 3'h0, 1'b0);
        step(4'h1, 3'h1, 1'b0);
        step(4'h2, 3'h2, 1'b0);
        step(4'h4, 3'h3, 1'b0);
        step(4'h9, 3'h0, 1'b1);
        $display("t_conn done");
    endtask

    task automatic t_stream;
        step(4'h0, 3'h1, 1'b0);
        step(4'h2, 3'h2, 1'b0);
        step(4'h4, 3'h3, 1'b0);
        @(posedge ref_clk_in);
        cmd_valid_in <= 1'b1;
        cmd_data_in <= 32'h0000_0011;
        @(posedge ref_clk_in);
        cmd_data_in <= 32'h0000_0022;
        @(posedge ref_clk_in);
        cmd_valid_in <= 1'b0;
        #1;
        chk("cmd_ready", 32'h0, {31'h0, cmd_ready_out});
        chk("drv_valid", 32'h1, {31'h0, drv_cmd_valid_out});
        chk("drv_data", 32'h0000_0011, drv_cmd_data_out);
        @(posedge ref_clk_in);
        drv_cmd_ready_in <= 1'b1;
        @(posedge ref_clk_in);
        #1;
        chk("drv_data", 32'h0000_0022, drv_cmd_data_out);
        @(posedge ref_clk_in);
        drv_cmd_ready_in <= 1'b0;
        #1;
        chk("drv_valid", 32'h0, {31'h0, drv_cmd_valid_out});
        @(posedge ref_clk_in);
        cmd_valid_in <= 1'b1;
        cmd_data_in <= 32'h0000_0033;
        @(posedge ref_clk_in);
        cmd_valid_in <= 1'b0;
        step(4'h5, 3'h2, 1'b1);
        chk("drv_valid", 32'h0, {31'h0, drv_cmd_valid_out});
        @(posedge ref_clk_in);
        cmd_valid_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        cmd_valid_in <= 1'b0;
        #1;
        chk("cmd_ready", 32'h1, {31'h0, cmd_ready_out});
        chk("drv_valid", 32'h0, {31'h0, drv_cmd_valid_out});
        $display("t_stream done");
    endtask

    task automatic t_misc;
        int n;
        pulse(5'h10);
        chk("tx_busy", 32'h1, {31'h0, msg_tx_busy_out});
        pulse(5'h10);
        chk("refused", 32'h1, {31'h0, msg_refused_out});
        pulse(5'h0C);
        chk("busy_pair", 32'h1, {30'h0, msg_tx_busy_out, msg_rx_busy_out});
        pulse(5'h02);
        chk("rx_busy", 32'h0, {31'h0, msg_rx_busy_out});
        pulse(5'h01);
        chk("attr", 32'h0001_0075, {15'h0, attr_hit_out, attr_data_out});
        @(posedge ref_clk_in);
        attr_id_in <= 8'h06;
        pulse(5'h01);
        chk("attr", 32'h0, {15'h0, attr_hit_out, attr_data_out});
        chk("leds", 32'h3, {30'h0, led_net_out, led_mod_out});
        chk("led_link", 32'h3, {30'h0, led_link_act_out});
        chk("port_mode", 32'h9, {28'h0, port_mode_out});
        n = 0;
        do begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end while (io_cycle_out !== 1'b1 && n < 300);
        n = 0;
        do begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end while (io_cycle_out !== 1'b1 && n < 300);
        chk("period", 32'd100, n);
        $display("t_misc done");
    endtask

    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    initial begin
        repeat (5000) @(posedge ref_clk_in);
        fails++;
        conclude();
    end

    initial begin
        {go, op, cmd_valid_in, cmd_data_in, drv_cmd_ready_in} = '0;
        {msg_tx_req_in, msg_tx_done_in, msg_rx_req_in, msg_rx_done_in, attr_rd_in} = '0;
        {attr_class_in, attr_inst_in, attr_id_in} = {8'h01, 8'h01, 8'h05};
        {port_link_in, port_speed100_in, port_full_duplex_in} = {2'h3, 2'h1, 2'h2};
        port_activity_in = 2'h0;
        fails = 0;
        checks = 0;
        rstn_in = 1'b0;
        repeat (8) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        t_conn();
        t_stream();
        t_misc();
        conclude();
    end
endmodule

// [testbench/ioc_master_model.sv]
/*
 * Behavioural network controller that raises one connection event pulse
 * for each event code the bench hands it, and offers the cyclic period.
 * Assumes go_in is high for exactly one clock cycle per event.
 */
module ioc_master_model (
    input  wire logic       go_in,
    input  wire logic [3:0] op_in,
    output logic      [9:0] ev_out,
    output logic      [6:0] period_ms_out
);
    assign period_ms_out = 7'h0A;
    always_comb begin
        ev_out = 10'h000;
        if (go_in) begin
            ev_out[op_in] = 1'b1;
        end
    end
endmodule
